// ---- rtl/lpc_pkg.sv ----
// Constants, encodings and behaviour summary for the low-power mode controller
//
// Behaviour
// - A wait-for-interrupt with standby_select_bit at 0 enters sleep.
// - Snooze is entered only from standby on a snooze trigger, select at 1.
// - Sleep ends on any interrupt or any reset available in sleep.
// - Standby and snooze end only on their wake interrupts or a reset.
// - Interrupt wake returns to execution; reset wake goes to reset state.
// - With subclock_select_bit at 0, mode field 11b/10b/01b is high/mid/low.
// - With subclock_select_bit at 1 the speed mode is subclock-speed.
// - All oscillators in high/mid; no main osc in low; only LOCO/sub in sub.
// - Clock ceilings 32/24/2 MHz and 32.768 kHz; no flash P/E in low/sub.
// - In sleep the core halts while peripherals and clocks keep running.
// - Standby stops core, most peripherals and clocks; snooze lets some run.
package lpc_pkg;

  // Low-power state
  typedef enum logic [1:0] {
    LPC_RUN,
    LPC_SLEEP,
    LPC_STANDBY,
    LPC_SNOOZE
  } lpc_state_t;

  // Operating power mode field encodings
  localparam logic [1:0] LPC_MODE_HIGH = 2'h3;
  localparam logic [1:0] LPC_MODE_MID = 2'h2;
  localparam logic [1:0] LPC_MODE_LOW = 2'h1;

  // Speed mode reported to the clock generator
  localparam logic [1:0] LPC_SPD_SUB = 2'h0;
  localparam logic [1:0] LPC_SPD_LOW = 2'h1;
  localparam logic [1:0] LPC_SPD_MID = 2'h2;
  localparam logic [1:0] LPC_SPD_HIGH = 2'h3;

  // Oscillator permit vector bits: hoco, moco, loco, main, sub
  localparam int LPC_OSC_HOCO = 4;
  localparam int LPC_OSC_MOCO = 3;
  localparam int LPC_OSC_LOCO = 2;
  localparam int LPC_OSC_MAIN = 1;
  localparam int LPC_OSC_SUB = 0;
  localparam logic [4:0] LPC_OSC_ALL = 5'h1F;
  localparam logic [4:0] LPC_OSC_NOMAIN = 5'h1D;
  localparam logic [4:0] LPC_OSC_SUBONLY = 5'h05;

  // Core clock ceilings in Hz
  localparam logic [25:0] LPC_FMAX_HIGH = 26'h1E84800;
  localparam logic [25:0] LPC_FMAX_MID = 26'h16E3600;
  localparam logic [25:0] LPC_FMAX_LOW = 26'h01E8480;
  localparam logic [25:0] LPC_FMAX_SUB = 26'h0008000;

  // Reset values
  localparam lpc_state_t LPC_STATE_RST = LPC_RUN;
  localparam logic [1:0] LPC_SPD_RST = LPC_SPD_HIGH;

endpackage : lpc_pkg

// ---- rtl/lpc_sync.sv ----
// Three-stage input synchroniser with agreement of the last two stages
`timescale 1ns/10ps
`default_nettype none
module lpc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // All state of the synchroniser
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } lpc_sync_regs_t;

  lpc_sync_regs_t r;
  lpc_sync_regs_t next_r;

  // Stage one is read only by stage two; per bit a change is accepted
  // once stages two and three agree, so a late settle is not seen twice
  always_comb begin
    next_r.s1 = din;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.q = (r.s2 & r.s3) | (r.q & (r.s2 | r.s3));
  end

  // Stage registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign dout = r.q;

endmodule : lpc_sync
`default_nettype wire

// ---- rtl/lpc_ctrl.sv ----
// Low-power mode controller: mode sequencing and power mode selection
`timescale 1ns/10ps
`default_nettype none
module lpc_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Core side, same clock
  input wire logic wfi_exec,
  input wire logic standby_select_bit,
  input wire logic [1:0] operating_power_mode_reg,
  input wire logic subclock_select_bit,
  // Wake and snooze sources, asynchronous
  input wire logic irq_any,
  input wire logic irq_standby_wake,
  input wire logic snooze_req,
  input wire logic lpm_reset_req,
  // Core control
  output logic core_halt,
  output logic wake_irq,
  output logic wake_reset,
  output logic [1:0] lp_state,
  // Clock generator side
  output logic periph_clk_en,
  output logic snooze_clk_en,
  output logic [1:0] speed_mode,
  output logic [4:0] osc_permit,
  output logic [25:0] core_clock_max_hz,
  output logic flash_pe_allow
);

  // All state of the controller
  typedef struct packed {
    lpc_pkg::lpc_state_t st;
    logic wake_irq;
    logic wake_reset;
    logic [1:0] spd;
  } lpc_regs_t;

  lpc_regs_t r;
  lpc_regs_t next_r;
  logic [3:0] sync_out;
  logic s_irq, s_swake, s_snz, s_rst;

  // Asynchronous wake sources cross through four flops
  lpc_sync #(.W(4)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .din({irq_any, irq_standby_wake, snooze_req, lpm_reset_req}),
    .dout(sync_out)
  );
  assign {s_irq, s_swake, s_snz, s_rst} = sync_out;

  // Speed mode decode; reserved 00b with subclock off is held as low-speed
  function automatic logic [1:0] lpc_speed(input logic sub,
                                           input logic [1:0] fld);
    if (sub) lpc_speed = lpc_pkg::LPC_SPD_SUB;
    else if (fld == lpc_pkg::LPC_MODE_HIGH) lpc_speed = lpc_pkg::LPC_SPD_HIGH;
    else if (fld == lpc_pkg::LPC_MODE_MID) lpc_speed = lpc_pkg::LPC_SPD_MID;
    else lpc_speed = lpc_pkg::LPC_SPD_LOW;
  endfunction : lpc_speed

  // Next-state logic
  always_comb begin
    next_r = r;
    next_r.wake_irq = 1'b0;
    next_r.wake_reset = 1'b0;
    next_r.spd = lpc_speed(subclock_select_bit, operating_power_mode_reg);
    case (r.st)
      lpc_pkg::LPC_RUN: begin
        if (wfi_exec) begin
          // Select bit chooses sleep or standby
          if (standby_select_bit) next_r.st = lpc_pkg::LPC_STANDBY;
          else next_r.st = lpc_pkg::LPC_SLEEP;
        end
      end
      lpc_pkg::LPC_SLEEP: begin
        // Reset takes priority over an interrupt in the same cycle
        if (s_rst) begin
          next_r.st = lpc_pkg::LPC_RUN;
          next_r.wake_reset = 1'b1;
        end else if (s_irq) begin
          next_r.st = lpc_pkg::LPC_RUN;
          next_r.wake_irq = 1'b1;
        end
      end
      lpc_pkg::LPC_STANDBY, lpc_pkg::LPC_SNOOZE: begin
        if (s_rst) begin
          next_r.st = lpc_pkg::LPC_RUN;
          next_r.wake_reset = 1'b1;
        end else if (s_swake) begin
          next_r.st = lpc_pkg::LPC_RUN;
          next_r.wake_irq = 1'b1;
        end else if (r.st == lpc_pkg::LPC_STANDBY && s_snz &&
                     standby_select_bit) begin
          next_r.st = lpc_pkg::LPC_SNOOZE;
        end
      end
      default: next_r.st = lpc_pkg::LPC_RUN;
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r.st <= lpc_pkg::LPC_STATE_RST;
      r.wake_irq <= 1'b0;
      r.wake_reset <= 1'b0;
      r.spd <= lpc_pkg::LPC_SPD_RST;
    end else begin
      r <= next_r;
    end
  end

  // Core and peripheral gating; sleep keeps the peripheral clock alive
  assign core_halt = (r.st != lpc_pkg::LPC_RUN);
  assign periph_clk_en = (r.st == lpc_pkg::LPC_RUN) ||
                         (r.st == lpc_pkg::LPC_SLEEP);
  assign snooze_clk_en = (r.st == lpc_pkg::LPC_SNOOZE);
  assign wake_irq = r.wake_irq;
  assign wake_reset = r.wake_reset;
  assign lp_state = r.st;
  assign speed_mode = r.spd;

  // Oscillator permits, ceiling and flash P/E; limits only, software sets
  // actual dividers (no power saving otherwise)
  always_comb begin
    case (r.spd)
      lpc_pkg::LPC_SPD_HIGH: begin
        osc_permit = lpc_pkg::LPC_OSC_ALL;
        core_clock_max_hz = lpc_pkg::LPC_FMAX_HIGH;
        flash_pe_allow = 1'b1;
      end
      lpc_pkg::LPC_SPD_MID: begin
        osc_permit = lpc_pkg::LPC_OSC_ALL;
        core_clock_max_hz = lpc_pkg::LPC_FMAX_MID;
        flash_pe_allow = 1'b1;
      end
      lpc_pkg::LPC_SPD_LOW: begin
        osc_permit = lpc_pkg::LPC_OSC_NOMAIN;
        core_clock_max_hz = lpc_pkg::LPC_FMAX_LOW;
        flash_pe_allow = 1'b0;
      end
      default: begin
        osc_permit = lpc_pkg::LPC_OSC_SUBONLY;
        core_clock_max_hz = lpc_pkg::LPC_FMAX_SUB;
        flash_pe_allow = 1'b0;
      end
    endcase
  end

  // Checks
  property p_wfi_sleep;
    @(posedge mclk) disable iff (!reset_n)
    (r.st == lpc_pkg::LPC_RUN && wfi_exec && !standby_select_bit)
      |=> lp_state == lpc_pkg::LPC_SLEEP;
  endproperty
  a_wfi_sleep: assert property (p_wfi_sleep) else $error("no sleep");

  property p_wfi_sby;
    @(posedge mclk) disable iff (!reset_n)
    (r.st == lpc_pkg::LPC_RUN && wfi_exec && standby_select_bit)
      |=> lp_state == lpc_pkg::LPC_STANDBY;
  endproperty
  a_wfi_sby: assert property (p_wfi_sby) else $error("no standby");

  property p_snz_src;
    @(posedge mclk) disable iff (!reset_n)
    $changed(lp_state) && lp_state == lpc_pkg::LPC_SNOOZE
      |-> $past(lp_state) == lpc_pkg::LPC_STANDBY;
  endproperty
  a_snz_src: assert property (p_snz_src) else $error("bad snooze");

  property p_sleep_wake;
    @(posedge mclk) disable iff (!reset_n)
    (r.st == lpc_pkg::LPC_SLEEP && (s_irq || s_rst))
      |=> lp_state == lpc_pkg::LPC_RUN && (wake_irq || wake_reset);
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep stuck");

  property p_sby_hold;
    @(posedge mclk) disable iff (!reset_n)
    (r.st == lpc_pkg::LPC_STANDBY && !s_swake && !s_rst)
      |=> lp_state != lpc_pkg::LPC_RUN;
  endproperty
  a_sby_hold: assert property (p_sby_hold) else $error("early wake");

  property p_rst_pri;
    @(posedge mclk) disable iff (!reset_n)
    (r.st != lpc_pkg::LPC_RUN && s_rst) |=> wake_reset && !wake_irq;
  endproperty
  a_rst_pri: assert property (p_rst_pri) else $error("reset wake");

  property p_sub;
    @(posedge mclk) disable iff (!reset_n)
    subclock_select_bit |=> speed_mode == lpc_pkg::LPC_SPD_SUB &&
      osc_permit == lpc_pkg::LPC_OSC_SUBONLY;
  endproperty
  a_sub: assert property (p_sub) else $error("sub mode");

  property p_high;
    @(posedge mclk) disable iff (!reset_n)
    (!subclock_select_bit && operating_power_mode_reg == 2'h3)
      |=> core_clock_max_hz == lpc_pkg::LPC_FMAX_HIGH && flash_pe_allow;
  endproperty
  a_high: assert property (p_high) else $error("high mode");

  property p_halt;
    @(posedge mclk) disable iff (!reset_n)
    (lp_state == lpc_pkg::LPC_SLEEP) |-> core_halt && periph_clk_en;
  endproperty
  a_halt: assert property (p_halt) else $error("sleep gating");

  c_sleep: cover property (@(posedge mclk) r.st == lpc_pkg::LPC_SLEEP
    ##1 r.st == lpc_pkg::LPC_RUN);
  c_snooze: cover property (@(posedge mclk) r.st == lpc_pkg::LPC_SNOOZE);
  c_sby_wake: cover property (@(posedge mclk) r.st == lpc_pkg::LPC_STANDBY
    ##1 wake_irq);

endmodule : lpc_ctrl
`default_nettype wire

// ---- test/lpc_core_model.sv ----
// Core-side model that issues wait-for-interrupt pulses to the controller
`timescale 1ns/10ps
`default_nettype none
module lpc_core_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Bench request and core state
  input wire logic go_wfi,
  input wire logic core_halt,
  // To controller
  output logic wfi_exec
);
  // A halted core runs no instruction, so no WFI leaves it while stopped
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wfi_exec <= 1'b0;
    end else begin
      wfi_exec <= go_wfi & ~core_halt;
    end
  end
endmodule : lpc_core_model
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the low-power mode controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic go_wfi = 1'b0;
  logic sel = 1'b0;
  logic [1:0] fld = 2'h3;
  logic sub = 1'b0;
  logic irq = 1'b0;
  logic irq_sw = 1'b0;
  logic snz = 1'b0;
  logic rst_req = 1'b0;
  logic wfi, halt, w_irq, w_rst, pclk, sclk, pe;
  logic [1:0] st, spd;
  logic [4:0] osc;
  logic [25:0] fmax;
  int num_errors = 0;
  int compares = 0;
  int seed = 37;
  int cycles = 0;
  int i;

  // Clock at 100 MHz
  always #5 mclk = ~mclk;

  lpc_core_model core (.mclk(mclk), .reset_n(reset_n), .go_wfi(go_wfi),
    .core_halt(halt), .wfi_exec(wfi));

  lpc_ctrl dut (.mclk(mclk), .reset_n(reset_n), .wfi_exec(wfi),
    .standby_select_bit(sel), .operating_power_mode_reg(fld),
    .subclock_select_bit(sub), .irq_any(irq), .irq_standby_wake(irq_sw),
    .snooze_req(snz), .lpm_reset_req(rst_req), .core_halt(halt),
    .wake_irq(w_irq), .wake_reset(w_rst), .lp_state(st),
    .periph_clk_en(pclk), .snooze_clk_en(sclk), .speed_mode(spd),
    .osc_permit(osc), .core_clock_max_hz(fmax), .flash_pe_allow(pe));

  task automatic give_verdict();
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [25:0] exp, got);
    compares++;
    if (got !== exp) begin
      $display("BAD %s expected %0h seen %0h", name, exp, got);
      num_errors++;
    end
  endtask : chk

  // Expected speed mode from field and subclock bit; 00 reads as low
  function automatic logic [1:0] exp_spd(input logic [1:0] f, input logic s);
    if (s) return lpc_pkg::LPC_SPD_SUB;
    if (f == 2'h3) return lpc_pkg::LPC_SPD_HIGH;
    if (f == 2'h2) return lpc_pkg::LPC_SPD_MID;
    return lpc_pkg::LPC_SPD_LOW;
  endfunction : exp_spd

  task automatic chk_mode();
    logic [1:0] e;
    e = exp_spd(fld, sub);
    chk("speed", e, spd);
    chk("osc", e == 2'h0 ? 5'h05 : e == 2'h1 ? 5'h1D : 5'h1F, osc);
    chk("fmax", e == 2'h3 ? 26'h1E84800 : e == 2'h2 ? 26'h16E3600 :
      e == 2'h1 ? 26'h01E8480 : 26'h0008000, fmax);
    chk("flash_pe", e[1], pe);
    chk("sw_clk_fits", 1'b1, sw_hz(e) <= fmax);
  endtask : chk_mode

  // Core clock that bench software programs for each speed mode
  function automatic logic [25:0] sw_hz(input logic [1:0] e);
    case (e)
      2'h3: return 26'h1E84800;
      2'h2: return 26'h0F42400;
      2'h1: return 26'h01E8480;
      default: return 26'h0008000;
    endcase
  endfunction : sw_hz

  task automatic do_wfi();
    @(posedge mclk) go_wfi <= 1'b1;
    @(posedge mclk) go_wfi <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
  endtask : do_wfi

  // Wait a bounded time for a wake pulse, then check it is one cycle
  task automatic wait_wake(input logic by_rst);
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 12 && !seen; n++) begin
      @(negedge mclk);
      seen = by_rst ? (w_rst === 1'b1) : (w_irq === 1'b1);
    end
    chk("wake", 1'b1, seen);
    chk("state_woken", 2'h0, st);
    chk("halt_woken", 1'b0, halt);
    @(negedge mclk);
    chk("wake_end", 1'b0, by_rst ? w_rst : w_irq);
  endtask : wait_wake

  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    chk("state_rst", 2'h0, st);
    chk_mode();
    // Every field and subclock code, then random ones
    for (i = 0; i < 30; i++) begin
      @(posedge mclk) {sub, fld} <= i < 8 ? i[2:0] : 3'($random(seed));
      @(posedge mclk);
      @(negedge mclk);
      chk_mode();
    end
    // Sleep: snooze trigger refused, any interrupt wakes
    do_wfi();
    chk("state_sleep", 2'h1, st);
    chk("halt", 1'b1, halt);
    chk("pclk_sleep", 1'b1, pclk);
    @(posedge mclk) snz <= 1'b1;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    chk("state_nosnz", 2'h1, st);
    @(posedge mclk);
    snz <= 1'b0;
    irq <= 1'b1;
    wait_wake(1'b0);
    @(posedge mclk) irq <= 1'b0;
    // Standby: plain interrupt refused, snooze entered, wake source ends it
    sel <= 1'b1;
    repeat (6) @(posedge mclk);
    do_wfi();
    chk("state_stby", 2'h2, st);
    chk("pclk_stby", 1'b0, pclk);
    @(posedge mclk) irq <= 1'b1;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    chk("state_irq_ign", 2'h2, st);
    @(posedge mclk);
    irq <= 1'b0;
    snz <= 1'b1;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    chk("state_snz", 2'h3, st);
    chk("sclk", 1'b1, sclk);
    @(posedge mclk);
    snz <= 1'b0;
    irq_sw <= 1'b1;
    wait_wake(1'b0);
    @(posedge mclk) irq_sw <= 1'b0;
    // Snooze trigger in run is refused
    snz <= 1'b1;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    chk("state_run_snz", 2'h0, st);
    @(posedge mclk);
    snz <= 1'b0;
    repeat (6) @(posedge mclk);
    // Reset request ends standby toward the reset state
    do_wfi();
    chk("state_stby_rst", 2'h2, st);
    @(posedge mclk) rst_req <= 1'b1;
    wait_wake(1'b1);
    @(posedge mclk) rst_req <= 1'b0;
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
